/* src/ioc_port_adc_ctrl.sv */
/*
  Pin and converter control block: three general pins, interrupt routing onto the serial
  data-out pin, and a converter start/done sequencer with its configuration registers.
  Assumes an AHB-Lite master, one 10 MHz clock and an analog converter that returns its
  result on conv_result when conv_finish pulses.
*/
// Functional notes
// - Bits 6..4 show pin 2..0 interrupt status when set as interrupt source.
// - Interrupt-on-data-out set and select high: drive low-active request onto data-out.
// - Pin set as direct output drives its direct value bit 2..0.
// - Pin set as direct input reads back its sampled level.
// - Writing 1 to bit 7 starts a measurement; reads 1 when finished.
// - Input select field picks sensor, single pins, differential pairs or ground.
// - Reference select: 0x bandgap, 10 third supply, 11 half supply.
// - Differential gain field scales full scale by gain plus one.
// - Offset field is sign-magnitude, bit 3 sign, bits 2..0 magnitude.
// - Offset low bits reset to zero; upper bits reserved.
// - Function codes falling, rising or change make a pin interrupt source.
// - Completed result goes to a read-only value register.
`timescale 1ns/1ps
module ioc_port_adc_ctrl
  import ioc_pkg::*;
#(
  parameter int CONV_CYCLES = IOC_CONV_CYCLES
) (
  input  wire logic        clock,
  input  wire logic        rst,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic [31:0]      hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire logic [2:0]  pin_in,
  output logic [2:0]       pin_out,
  output logic [2:0]       pin_oe_n,
  input  wire logic        chip_select_n,
  input  wire logic        sdo_serial_data,
  input  wire logic        sdo_serial_oe_n,
  output logic             sdo_out,
  output logic             sdo_oe_n,
  input  wire logic        interrupt_request_n,
  output logic             conv_start,
  output ioc_conv_setup_t  conv_setup,
  input  wire logic [7:0]  conv_result,
  input  wire logic        conv_finish,
  output logic             conv_timeout
);
  typedef enum logic [1:0] {IOC_IDLE, IOC_BUSY, IOC_DONE} ioc_conv_state_t;

  logic [2:0]      pin_level;
  logic [2:0]      pin_level_d1_q;
  logic [2:0]      ext_status_q;
  logic [2:0]      direct_value_q;
  logic            irq_on_sdo_q;
  logic [2:0]      conv_sel_q;
  logic [1:0]      conv_ref_q;
  logic [1:0]      conv_gain_q;
  logic [3:0]      offset_q;
  logic [7:0]      result_q;
  logic [4:0]      pin_func_q [3];
  ioc_conv_state_t conv_state_q;
  logic [31:0]     conv_count_q;
  logic            cs_n_level;

  logic            wr_pend_q;
  logic [7:0]      wr_idx_q;
  logic            addr_phase;
  logic [7:0]      idx;
  logic            start_wr;
  logic [2:0]      is_ext;
  logic [2:0]      is_din;
  logic [2:0]      is_dout;
  logic [2:0]      ext_hit;
  logic            port_rd;

  genvar g;
  generate
    for (g = 0; g < 3; g++) begin : gen_pin
      ioc_pin_sync u_sync (
        .clock (clock),
        .rst   (rst),
        .pin   (pin_in[g]),
        .level (pin_level[g])
      );
      assign is_ext[g]  = (pin_func_q[g] == IOC_FN_EXT_FALL) || (pin_func_q[g] == IOC_FN_EXT_RISE) ||
                          (pin_func_q[g] == IOC_FN_EXT_CHANGE);
      assign is_din[g]  = (pin_func_q[g] == IOC_FN_DIRECT_IN);
      assign is_dout[g] = (pin_func_q[g] == IOC_FN_DIRECT_OUT);
    end
  endgenerate

  ioc_pin_sync u_cs_sync (
    .clock (clock),
    .rst   (rst),
    .pin   (chip_select_n),
    .level (cs_n_level)
  );

  // Bus: address phase captured, writes land in the data phase, zero wait states
  assign addr_phase = hsel && hready && htrans[1];
  assign idx        = haddr[9:2];
  assign hreadyout  = 1'b1;
  assign hresp      = 1'b0;
  assign port_rd    = addr_phase && !hwrite && (idx == IOC_IDX_IO_PORT_CFG);

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      wr_pend_q <= 1'b0;
      wr_idx_q  <= 8'h00;
    end else begin
      wr_pend_q <= addr_phase && hwrite;
      wr_idx_q  <= idx;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      hrdata <= 32'h0000_0000;
    end else if (addr_phase && !hwrite) begin
      case (idx)
        IOC_IDX_IO_PORT_CFG: hrdata <= {24'h000000, 1'b0, ext_status_q, irq_on_sdo_q,
                                        (direct_value_q & ~is_din) | (pin_level & is_din)};
        IOC_IDX_CONV_CFG:    hrdata <= {24'h000000, conv_state_q == IOC_DONE,
                                        conv_sel_q, conv_ref_q, conv_gain_q};
        IOC_IDX_AMP_OFFSET:  hrdata <= {28'h0000000, offset_q};
        IOC_IDX_CONV_VALUE:  hrdata <= {24'h000000, result_q};
        IOC_IDX_PIN_FUNC0:   hrdata <= {27'h0000000, pin_func_q[0]};
        IOC_IDX_PIN_FUNC1:   hrdata <= {27'h0000000, pin_func_q[1]};
        IOC_IDX_PIN_FUNC2:   hrdata <= {27'h0000000, pin_func_q[2]};
        default:             hrdata <= 32'h0000_0000;
      endcase
    end
  end

  // Control registers
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      direct_value_q <= IOC_RST_DIRECT[2:0];
      irq_on_sdo_q   <= IOC_RST_DIRECT[3];
      {conv_sel_q, conv_ref_q, conv_gain_q} <= IOC_RST_CONV_CFG;
      offset_q       <= IOC_RST_OFFSET;
      pin_func_q[0]  <= IOC_RST_PIN_FUNC;
      pin_func_q[1]  <= IOC_RST_PIN_FUNC;
      pin_func_q[2]  <= IOC_RST_PIN_FUNC;
    end else if (wr_pend_q) begin
      case (wr_idx_q)
        IOC_IDX_IO_PORT_CFG: begin
          irq_on_sdo_q   <= hwdata[IOC_BIT_IRQ_ON_SDO];
          direct_value_q <= hwdata[2:0];
        end
        IOC_IDX_CONV_CFG: begin
          conv_sel_q  <= hwdata[IOC_BIT_SEL_LO +: 3];
          conv_ref_q  <= hwdata[IOC_BIT_REF_LO +: 2];
          conv_gain_q <= hwdata[IOC_BIT_GAIN_LO +: 2];
        end
        IOC_IDX_AMP_OFFSET: offset_q      <= hwdata[3:0];
        IOC_IDX_PIN_FUNC0:  pin_func_q[0] <= hwdata[4:0];
        IOC_IDX_PIN_FUNC1:  pin_func_q[1] <= hwdata[4:0];
        IOC_IDX_PIN_FUNC2:  pin_func_q[2] <= hwdata[4:0];
        default: ;
      endcase
    end
  end

  // Edge events of pins set as interrupt sources
  always_comb begin
    ext_hit = 3'b000;
    for (int i = 0; i < 3; i++) begin
      case (pin_func_q[i])
        IOC_FN_EXT_FALL:   ext_hit[i] = pin_level_d1_q[i] && !pin_level[i];
        IOC_FN_EXT_RISE:   ext_hit[i] = !pin_level_d1_q[i] && pin_level[i];
        IOC_FN_EXT_CHANGE: ext_hit[i] = pin_level_d1_q[i] != pin_level[i];
        default:           ext_hit[i] = 1'b0;
      endcase
    end
  end

  // External interrupt status: set by edge, cleared when the port register is read; set wins
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      pin_level_d1_q <= 3'b000;
      ext_status_q   <= 3'b000;
    end else begin
      pin_level_d1_q <= pin_level;
      for (int i = 0; i < 3; i++) begin
        if (is_ext[i] && ext_hit[i]) begin
          ext_status_q[i] <= 1'b1;
        end else if (!is_ext[i] || port_rd) begin
          ext_status_q[i] <= 1'b0;
        end
      end
    end
  end

  // Pins
  assign pin_out  = direct_value_q;
  assign pin_oe_n = ~is_dout;

  // Data-out pin carries the request while deselected
  always_comb begin
    if (irq_on_sdo_q && cs_n_level) begin
      sdo_out  = interrupt_request_n;
      sdo_oe_n = 1'b0;
    end else begin
      sdo_out  = sdo_serial_data;
      sdo_oe_n = sdo_serial_oe_n;
    end
  end

  // Converter sequencer
  assign start_wr = wr_pend_q && wr_idx_q == IOC_IDX_CONV_CFG && hwdata[IOC_BIT_START_DONE];

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      conv_state_q <= IOC_IDLE;
      conv_count_q <= 32'h0000_0000;
      result_q     <= 8'h00;
      conv_start   <= 1'b0;
      conv_timeout <= 1'b0;
    end else begin
      conv_start <= 1'b0;
      case (conv_state_q)
        IOC_IDLE, IOC_DONE: begin
          if (start_wr) begin
            conv_state_q <= IOC_BUSY;
            conv_count_q <= 32'h0000_0000;
            conv_start   <= 1'b1;
            conv_timeout <= 1'b0;
          end
        end
        IOC_BUSY: begin
          conv_count_q <= conv_count_q + 32'h0000_0001;
          if (conv_finish) begin
            result_q     <= conv_result;
            conv_state_q <= IOC_DONE;
          end else if (conv_count_q >= 32'(CONV_CYCLES)) begin
            conv_timeout <= 1'b1;
            conv_state_q <= IOC_DONE;
          end
        end
        default: conv_state_q <= IOC_IDLE;
      endcase
    end
  end

  // Analog setup decoded from the configuration fields
  always_comb begin
    conv_setup.sel          = conv_sel_q;
    conv_setup.ref_sel      = conv_ref_q;
    conv_setup.gain         = conv_gain_q;
    conv_setup.differential = conv_sel_q[2] && conv_sel_q != 3'h7;
    conv_setup.offset       = offset_q;
  end

  // Checks
  sequence s_start_taken;
    start_wr && conv_state_q != IOC_BUSY;
  endsequence
  sequence s_busy_pulse;
    conv_state_q == IOC_BUSY && conv_start ##1 !conv_start;
  endsequence
  property p_start_busy;
    @(posedge clock) disable iff (rst) s_start_taken |=> s_busy_pulse;
  endproperty
  a_start_busy: assert property (p_start_busy)
    else $error("start did not enter busy");
  sequence s_finish_seen;
    conv_state_q == IOC_BUSY && conv_finish;
  endsequence
  property p_finish_done;
    @(posedge clock) disable iff (rst) s_finish_seen |=>
      conv_state_q == IOC_DONE && result_q == $past(conv_result);
  endproperty
  a_finish_done: assert property (p_finish_done)
    else $error("result not captured");
  property p_sdo_irq;
    @(posedge clock) disable iff (rst) irq_on_sdo_q && cs_n_level |-> sdo_out == interrupt_request_n && !sdo_oe_n;
  endproperty
  a_sdo_irq: assert property (p_sdo_irq)
    else $error("request not on data-out");
  property p_dout;
    @(posedge clock) disable iff (rst) is_dout[0] |-> !pin_oe_n[0] && pin_out[0] == direct_value_q[0];
  endproperty
  a_dout: assert property (p_dout)
    else $error("pin 0 not driven");
  property p_ext_clear;
    @(posedge clock) disable iff (rst) !is_ext[1] |=> !ext_status_q[1];
  endproperty
  a_ext_clear: assert property (p_ext_clear)
    else $error("status set on non-interrupt pin");
  property p_rise;
    @(posedge clock) disable iff (rst)
      pin_func_q[2] == IOC_FN_EXT_RISE && $rose(pin_level[2]) && $stable(pin_func_q[2]) |=> ext_status_q[2];
  endproperty
  a_rise: assert property (p_rise)
    else $error("rising edge missed");
  property p_wait_bounded;
    @(posedge clock) disable iff (rst) conv_state_q == IOC_BUSY |-> conv_count_q <= 32'(CONV_CYCLES);
  endproperty
  a_wait_bounded: assert property (p_wait_bounded)
    else $error("conversion overran");
  property p_diff;
    @(posedge clock) disable iff (rst) conv_sel_q == 3'h7 |-> !conv_setup.differential;
  endproperty
  a_diff: assert property (p_diff)
    else $error("ground taken as differential");
  property p_read_clears;
    @(posedge clock) disable iff (rst) port_rd && ext_hit == 3'b000 |=> ext_status_q == 3'b000;
  endproperty
  a_read_clears: assert property (p_read_clears)
    else $error("status not cleared by read");
  property p_set_wins;
    @(posedge clock) disable iff (rst) ext_hit[0] |=> ext_status_q[0];
  endproperty
  a_set_wins: assert property (p_set_wins)
    else $error("pin 0 event lost");
  property p_status_hold;
    @(posedge clock) disable iff (rst) ext_status_q[2] && is_ext[2] && !port_rd |=> ext_status_q[2];
  endproperty
  a_status_hold: assert property (p_status_hold)
    else $error("pin 2 status dropped");
  property p_din_read;
    @(posedge clock) disable iff (rst)
      port_rd |=> (hrdata[2:0] & $past(is_din)) == ($past(pin_level) & $past(is_din));
  endproperty
  a_din_read: assert property (p_din_read)
    else $error("direct input level not read back");
  property p_no_abort;
    @(posedge clock) disable iff (rst)
      conv_state_q == IOC_BUSY && !conv_finish && conv_count_q < 32'(CONV_CYCLES) |=> conv_state_q == IOC_BUSY;
  endproperty
  a_no_abort: assert property (p_no_abort)
    else $error("conversion left busy early");
  property p_offset_write;
    @(posedge clock) disable iff (rst)
      wr_pend_q && wr_idx_q == IOC_IDX_AMP_OFFSET |=> offset_q == $past(hwdata[3:0]);
  endproperty
  a_offset_write: assert property (p_offset_write)
    else $error("offset write lost");
endmodule

/* src/ioc_pkg.sv */
/*
  Package for the pin and converter control block: register offsets, field positions,
  reset values, timing counts and carrier structs.
  Assumes one 10 MHz clock and an AHB-Lite register bus with 32-bit data.
*/
package ioc_pkg;
  // Byte addresses are four times the register index
  localparam logic [7:0] IOC_IDX_IO_PORT_CFG = 8'h0E;
  localparam logic [7:0] IOC_IDX_CONV_CFG    = 8'h0F;
  localparam logic [7:0] IOC_IDX_AMP_OFFSET  = 8'h10;
  localparam logic [7:0] IOC_IDX_CONV_VALUE  = 8'h11;
  localparam logic [7:0] IOC_IDX_PIN_FUNC0   = 8'h20;
  localparam logic [7:0] IOC_IDX_PIN_FUNC1   = 8'h21;
  localparam logic [7:0] IOC_IDX_PIN_FUNC2   = 8'h22;

  localparam int IOC_BIT_EXT_STATUS_LO = 4;
  localparam int IOC_BIT_IRQ_ON_SDO    = 3;
  localparam int IOC_BIT_START_DONE    = 7;
  localparam int IOC_BIT_SEL_LO        = 4;
  localparam int IOC_BIT_REF_LO        = 2;
  localparam int IOC_BIT_GAIN_LO       = 0;

  localparam logic [4:0] IOC_FN_DIRECT_IN  = 5'h03;
  localparam logic [4:0] IOC_FN_EXT_FALL   = 5'h04;
  localparam logic [4:0] IOC_FN_EXT_RISE   = 5'h05;
  localparam logic [4:0] IOC_FN_EXT_CHANGE = 5'h06;
  localparam logic [4:0] IOC_FN_DIRECT_OUT = 5'h0A;

  localparam logic [3:0] IOC_RST_DIRECT    = 4'h0;
  localparam logic [6:0] IOC_RST_CONV_CFG  = 7'h00;
  localparam logic [3:0] IOC_RST_OFFSET    = 4'h0;
  localparam logic [4:0] IOC_RST_PIN_FUNC  = 5'h00;

  localparam int IOC_CLK_HZ         = 10_000_000;
  localparam int IOC_CONV_TIME_NS   = 305_000;
  localparam int IOC_CONV_CYCLES    = (IOC_CONV_TIME_NS * (IOC_CLK_HZ / 1_000_000) + 999) / 1000;

  typedef struct packed {
    logic [2:0] sel;
    logic [1:0] ref_sel;
    logic [1:0] gain;
    logic       differential;
    logic [3:0] offset;
  } ioc_conv_setup_t;
endpackage

/* src/ioc_pin_sync.sv */
/*
  Three-flop pin synchroniser with agreement filter.
  Assumes an asynchronous pin level and one clock domain.
*/
`timescale 1ns/1ps
module ioc_pin_sync (
  input  wire logic clock,
  input  wire logic rst,
  input  wire logic pin,
  output logic      level
);
  logic s1_q;
  logic s2_q;
  logic s3_q;

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      s1_q <= 1'b0;
      s2_q <= 1'b0;
      s3_q <= 1'b0;
    end else begin
      s1_q <= pin;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // Change only once second and third agree
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      level <= 1'b0;
    end else if (s2_q == s3_q) begin
      level <= s3_q;
    end
  end
endmodule

/* tb/ioc_conv_model.sv */
/*
  Converter model for the bench: answers each start pulse with a result.
  Assumes conv_start is a one-cycle pulse on the rising edge of clock.
*/
`timescale 1ns/1ps
module ioc_conv_model (
  input  wire logic       clock,
  input  wire logic       conv_start,
  output logic [7:0]      conv_result,
  output logic            conv_finish,
  output logic [7:0]      last,
  output int              starts
);
  logic [7:0] r;
  initial begin
    conv_result = 8'hA5;
    conv_finish = 1'b0;
    last = 8'h00;
    starts = 0;
    forever begin
      @(posedge clock);
      if (conv_start === 1'b1) begin
        starts++;
        // Slow or prompt, always inside the timeout window
        repeat ($urandom_range(14, 8)) @(posedge clock);
        r = 8'($urandom);
        conv_result <= r;
        last <= r;
        conv_finish <= 1'b1;
        @(posedge clock);
        conv_finish <= 1'b0;
        conv_result <= ~r;
      end
    end
  end
endmodule

/* tb/ioc_port_adc_ctrl_tb.sv */
/*
  Self-checking bench for the pin and converter control block.
  Assumes zero-wait AHB-Lite slave and the converter model as far side.
*/
`timescale 1ns/1ps
module ioc_port_adc_ctrl_tb;
  import ioc_pkg::*;
  logic            clock, rst, hsel, hwrite, hready, hreadyout, hresp, chip_select_n;
  logic            sdo_serial_data, sdo_serial_oe_n, sdo_out, sdo_oe_n, interrupt_request_n;
  logic            conv_start, conv_finish, conv_timeout;
  logic [7:0]      res_q [$];
  logic [31:0]     haddr, hwdata, hrdata, rd, cfg, v;
  logic [1:0]      htrans;
  logic [2:0]      hsize, pin_in, pin_out, pin_oe_n, st;
  logic [7:0]      conv_result, last;
  logic [4:0]      code [3];
  ioc_conv_setup_t conv_setup;
  int              miscompares, checks, cyc, n, k, starts;

  assign hready = hreadyout;

  ioc_port_adc_ctrl #(.CONV_CYCLES(20)) u_dut (
    .clock(clock), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .pin_in(pin_in), .pin_out(pin_out), .pin_oe_n(pin_oe_n),
    .chip_select_n(chip_select_n), .sdo_serial_data(sdo_serial_data),
    .sdo_serial_oe_n(sdo_serial_oe_n), .sdo_out(sdo_out), .sdo_oe_n(sdo_oe_n),
    .interrupt_request_n(interrupt_request_n), .conv_start(conv_start), .conv_setup(conv_setup),
    .conv_result(conv_result), .conv_finish(conv_finish), .conv_timeout(conv_timeout)
  );

  ioc_conv_model u_conv (
    .clock(clock), .conv_start(conv_start), .conv_result(conv_result),
    .conv_finish(conv_finish), .last(last), .starts(starts)
  );

  // Reference of the value register: every delivered result, in order
  always @(posedge clock) begin
    if (conv_finish === 1'b1) begin
      res_q.push_back(conv_result);
    end
  end

  initial begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end

  task automatic stop_test();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  always @(posedge clock) begin
    cyc++;
    if (cyc == 30000) begin
      miscompares++;
      stop_test();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    checks++;
    if (got !== exp) begin
      miscompares++;
      $display("FAIL %0t %s got %0h exp %0h", $time, m, got, exp);
    end
  endtask

  // Single word transfer; returns read data taken at the data phase edge
  task automatic bus(input logic w, input logic [7:0] idx, input logic [31:0] d, output logic [31:0] q);
    @(posedge clock);
    hsel <= 1'b1;
    haddr <= {22'h0, idx, 2'b00};
    htrans <= 2'b10;
    hwrite <= w;
    @(posedge clock);
    while (hready !== 1'b1) @(posedge clock);
    htrans <= 2'b00;
    hwdata <= d;
    @(posedge clock);
    while (hready !== 1'b1) @(posedge clock);
    q = hrdata;
    chk(hresp, 32'h0, "okay response");
  endtask

  initial begin
    rst = 1'b1;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    pin_in = 3'h0;
    chip_select_n = 1'b0;
    sdo_serial_data = 1'b0;
    sdo_serial_oe_n = 1'b1;
    interrupt_request_n = 1'b1;
    code = '{IOC_FN_EXT_FALL, IOC_FN_EXT_RISE, IOC_FN_EXT_CHANGE};
    st = 3'b101;
    rd = $urandom(32'h24190386);
    repeat (12) @(posedge clock);
    rst <= 1'b0;
    bus(0, IOC_IDX_AMP_OFFSET, 32'h0, rd);
    chk(rd[3:0], 32'h0, "offset reset");
    $display("reset test done");
    for (int p = 0; p < 3; p++) bus(1, IOC_IDX_PIN_FUNC0 + 8'(p), 32'(IOC_FN_DIRECT_OUT), rd);
    repeat (4) begin
      v = $urandom_range(7);
      bus(1, IOC_IDX_IO_PORT_CFG, v, rd);
      @(negedge clock);
      chk(pin_out, v, "direct out");
      chk(pin_oe_n, 32'h0, "out enable");
    end
    $display("direct out test done");
    for (int p = 0; p < 3; p++) bus(1, IOC_IDX_PIN_FUNC0 + 8'(p), 32'(IOC_FN_DIRECT_IN), rd);
    @(negedge clock);
    chk(pin_oe_n, 32'h7, "in released");
    repeat (4) begin
      pin_in <= 3'($urandom);
      repeat (6) @(posedge clock);
      bus(0, IOC_IDX_IO_PORT_CFG, 32'h0, rd);
      chk(rd[2:0], pin_in, "direct in");
    end
    $display("direct in test done");
    for (int p = 0; p < 3; p++) begin
      for (int c = 0; c < 3; c++) begin
        pin_in[p] <= st[c];
        repeat (6) @(posedge clock);
        bus(1, IOC_IDX_PIN_FUNC0 + 8'(p), 32'(code[c]), rd);
        bus(0, IOC_IDX_IO_PORT_CFG, 32'h0, rd);
        pin_in[p] <= ~st[c];
        repeat (6) @(posedge clock);
        bus(0, IOC_IDX_IO_PORT_CFG, 32'h0, rd);
        chk(rd[6:4], 32'(1 << p), "ext status");
      end
    end
    $display("interrupt status test done");
    for (int i = 0; i < 8; i++) begin
      bus(1, IOC_IDX_IO_PORT_CFG, {28'h0, i[2], 3'h0}, rd);
      chip_select_n <= i[1];
      interrupt_request_n <= i[0];
      sdo_serial_data <= ~i[0];
      sdo_serial_oe_n <= i[0];
      repeat (6) @(posedge clock);
      @(negedge clock);
      v = (i[2] && i[1]) ? {30'h0, i[0], 1'b0} : {30'h0, ~i[0], i[0]};
      chk({sdo_out, sdo_oe_n}, v, "data-out routing");
    end
    $display("data-out test done");
    for (int s = 0; s < 8; s++) begin
      cfg = {24'h0, 1'b1, 3'(s), 4'($urandom)};
      n = starts;
      bus(1, IOC_IDX_CONV_CFG, cfg, rd);
      repeat (2) @(negedge clock);
      chk(conv_setup.sel, 32'(s), "input select");
      chk(conv_setup.ref_sel, cfg[3:2], "reference");
      chk({conv_setup.differential, conv_setup.gain}, {s >= 4 && s != 7, cfg[1:0]}, "gain");
      bus(0, IOC_IDX_CONV_CFG, 32'h0, rd);
      chk(rd[7], 32'h0, "busy reads 0");
      bus(1, IOC_IDX_CONV_CFG, cfg & 32'h7F, rd);
      k = 0;
      do begin
        bus(0, IOC_IDX_CONV_CFG, 32'h0, rd);
        k++;
      end while (rd[7] !== 1'b1 && k < 40);
      chk(rd[7], 32'h1, "done");
      chk(32'(starts), 32'(n + 1), "one start");
      chk(conv_timeout, 32'h0, "no timeout");
      bus(0, IOC_IDX_CONV_VALUE, 32'h0, rd);
      chk(rd[7:0], last, "result");
      chk(32'(res_q.size()), 32'h1, "one result queued");
      if (res_q.size() > 0) chk(rd[7:0], res_q.pop_front(), "result model");
    end
    $display("converter test done");
    repeat (4) begin
      v = $urandom;
      bus(1, IOC_IDX_AMP_OFFSET, v, rd);
      bus(0, IOC_IDX_AMP_OFFSET, 32'h0, rd);
      chk(rd[3:0], v[3:0], "offset readback");
      chk(conv_setup.offset, v[3:0], "offset field");
    end
    $display("offset test done");
    rst <= 1'b1;
    repeat (2) @(posedge clock);
    rst <= 1'b0;
    bus(0, IOC_IDX_AMP_OFFSET, 32'h0, rd);
    chk(rd[3:0], 32'h0, "offset after reset");
    $display("second reset test done");
    stop_test();
  end
endmodule
